// ==== hdl/ess_camera.sv ====
// Camera end: exposure sequencing, dual-register readout and pixel reordering.
//
// Behaviour
// - Level mode: expose while low, read on rise.
// - Programmable: expose on rise, read at timeout.
// - Programmable mode ignores the sync falling edge.
// - Free-run uses internal control, frames continuously.
// - Controller selects mode and loads timers.
// - Pixels 1-502 left, 503-1004 right.
// - Left ascends, right descends from 1004.
// - Shifting paced by the 40 MHz data rate; the code divides 250 MHz by 6, about 41.7 MHz.
// - Ten-bit pixels leave in ascending order.
// - Lines output progressively until frame complete.
// - Frame per sync period, periodic or not; the code drops a new frame start while a frame is still leaving.
// - Level sync high 4 us, low 10 us.
// - Sync period at least 20.83 ms.
// - Start lag up to 25 us if frame valid.
// - Busy case exposure: low time plus 94.5 us.
// - Idle case: start 3.7 us later, plus 94.5.
// - Frame valid low 1 us before sync rises.
// - Frame valid low 1 us before sync falls.
// - Free-run: low timer1, high timer2.
// - Exposure output high during each exposure.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ess_camera (
  // Clock and reset.
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  // Link to the grabber.
  ess_link_if.camera      LINK,
  // Sensor sample input, one 10-bit value per pixel position.
  input  wire logic [9:0] SENSOR_SAMPLE,
  output logic [10:0]     SENSOR_ADDR
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ESS_ST_IDLE  = 3'h0,
    ESS_ST_LAG   = 3'h1,
    ESS_ST_EXP   = 3'h2,
    ESS_ST_TAIL  = 3'h3,
    ESS_ST_FREEH = 3'h4
  } ess_cam_st_t;

  typedef struct packed {
    logic [1:0]  sync_meta;
    logic        sync_s;
    logic        sync_old;
    ess_cam_st_t st;
    logic [1:0]  mode;
    logic [31:0] t1;
    logic [31:0] t2;
    logic [1:0]  cfg_mode;
    logic [31:0] cfg_t1;
    logic [31:0] cfg_t2;
    logic [31:0] cnt;
    logic        exposing;
    logic        rd_go;
    logic        reading;
    logic [10:0] pix;
    logic [10:0] line;
    logic [10:0] gap;
    logic [2:0]  div;
    logic        fv;
    logic        lv;
    logic [9:0]  data;
    logic [10:0] addr;
  } ess_cam_t;

  ess_cam_t s_q;
  ess_cam_t s_d;

  logic rise;
  logic fall;

  // Maps output order onto the two shift registers: left ascends, right descends.
  function automatic logic [10:0] ess_reg_pos(input logic [10:0] k);
    if (k < 11'(ess_pkg::HALF_PIX)) begin
      ess_reg_pos = k;
    end else begin
      ess_reg_pos = 11'(ess_pkg::LINE_PIX - 1) - (k - 11'(ess_pkg::HALF_PIX));
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sync_meta = {s_q.sync_meta[0], LINK.sync};
    s_d.sync_s    = s_q.sync_meta[1];
    s_d.sync_old  = s_q.sync_s;
    rise = s_q.sync_s & ~s_q.sync_old;
    fall = ~s_q.sync_s & s_q.sync_old;
    s_d.rd_go = 1'b0;
    // Settings are staged here and only copied in when the idle state starts a new sequence.
    if (LINK.cfg_stb) begin
      s_d.cfg_mode = LINK.mode;
      s_d.cfg_t1   = LINK.timer1;
      s_d.cfg_t2   = LINK.timer2;
    end
    case (s_q.st)
      ESS_ST_IDLE: begin
        s_d.exposing = 1'b0;
        if (s_q.cfg_mode == ess_pkg::ESS_MODE_FREE) begin
          s_d.mode = s_q.cfg_mode;
          s_d.t1   = s_q.cfg_t1;
          s_d.t2   = s_q.cfg_t2;
          s_d.cnt  = s_q.cfg_t1 + 32'(ess_pkg::EXTRA_EXP_CYC);
          s_d.exposing = 1'b1;
          s_d.st = ESS_ST_EXP;
        end else if ((s_q.cfg_mode == ess_pkg::ESS_MODE_LEVEL && fall) ||
                     (s_q.cfg_mode == ess_pkg::ESS_MODE_PROG && rise)) begin
          s_d.mode = s_q.cfg_mode;
          s_d.t1   = s_q.cfg_t1;
          s_d.t2   = s_q.cfg_t2;
          // Busy frame lags the 25 us maximum jitter delay; idle frame lags the fixed start delay.
          s_d.cnt  = s_q.fv ? 32'(ess_pkg::JITTER_MAX_CYC) : 32'(ess_pkg::START_LAG_CYC);
          s_d.st   = ESS_ST_LAG;
        end
      end
      ESS_ST_LAG: begin
        if (s_q.cnt <= 32'h0000_0001) begin
          s_d.exposing = 1'b1;
          s_d.cnt = s_q.t1 + 32'(ess_pkg::EXTRA_EXP_CYC);
          s_d.st  = (s_q.mode == ess_pkg::ESS_MODE_LEVEL) ? ESS_ST_EXP : ESS_ST_EXP;
        end else begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;
        end
      end
      ESS_ST_EXP: begin
        // Level mode ends on the sync rise; the others count their timer.
        if (s_q.mode == ess_pkg::ESS_MODE_LEVEL) begin
          if (rise) begin
            s_d.cnt = 32'(ess_pkg::EXTRA_EXP_CYC);
            s_d.st  = ESS_ST_TAIL;
          end
        end else if (s_q.cnt <= 32'h0000_0001) begin
          s_d.exposing = 1'b0;
          s_d.rd_go    = 1'b1;
          s_d.cnt      = s_q.t2;
          s_d.st = (s_q.mode == ess_pkg::ESS_MODE_FREE) ? ESS_ST_FREEH : ESS_ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;
        end
      end
      ESS_ST_TAIL: begin
        if (s_q.cnt <= 32'h0000_0001) begin
          s_d.exposing = 1'b0;
          s_d.rd_go    = 1'b1;
          s_d.st       = ESS_ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;
        end
      end
      ESS_ST_FREEH: begin
        // Internal control signal high phase.
        if (s_q.cnt <= 32'h0000_0001) begin
          s_d.st = ESS_ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;
        end
      end
      default: begin
        s_d.st = ESS_ST_IDLE;
      end
    endcase

    // -------------------------------------------------------------------------
    // Readout: a new frame start is dropped if a frame is still leaving.
    // -------------------------------------------------------------------------
    if (s_q.rd_go && !s_q.reading) begin
      s_d.reading = 1'b1;
      s_d.line = 11'h000;
      s_d.pix  = 11'h000;
      s_d.gap  = 11'h000;
      s_d.fv   = 1'b1;
    end
    s_d.div = (s_q.div == 3'(ess_pkg::DATA_DIV - 1)) ? 3'h0 : s_q.div + 3'h1;
    if (s_q.reading && s_q.div == 3'h0) begin
      if (s_q.gap != 11'h000) begin
        s_d.gap = s_q.gap - 11'h001;
        s_d.lv  = 1'b0;
      end else begin
        s_d.lv   = 1'b1;
        s_d.addr = ess_reg_pos(s_q.pix);
        s_d.data = SENSOR_SAMPLE;
        if (s_q.pix == 11'(ess_pkg::LINE_PIX - 1)) begin
          s_d.pix = 11'h000;
          s_d.gap = 11'(ess_pkg::LINE_GAP_CYC / ess_pkg::DATA_DIV);
          if (s_q.line == 11'(ess_pkg::FRAME_LINES - 1)) begin
            s_d.reading = 1'b0;
            s_d.gap = 11'h000;
          end else begin
            s_d.line = s_q.line + 11'h001;
          end
        end else begin
          s_d.pix = s_q.pix + 11'h001;
        end
      end
    end else if (!s_q.reading && s_q.div == 3'h0) begin
      s_d.lv = 1'b0;
      s_d.fv = 1'b0;
    end
    // The address leads the sample by one data cycle, so ask ahead.
    s_d.addr = ess_reg_pos(s_d.pix);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
      // The grabber resets its sync high, so the edge detector starts high too.
      // Starting it low would show a false rise just after reset.
      s_q.sync_meta <= 2'h3;
      s_q.sync_s <= 1'b1;
      s_q.sync_old <= 1'b1;
      s_q.cfg_t1 <= ess_pkg::TIMER1_RST;
      s_q.cfg_t2 <= ess_pkg::TIMER2_RST;
      s_q.cfg_mode <= ess_pkg::MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops.
  assign LINK.exposing    = s_q.exposing;
  assign LINK.frame_valid = s_q.fv;
  assign LINK.line_valid  = s_q.lv;
  assign LINK.pixel       = s_q.data;
  assign SENSOR_ADDR      = s_q.addr;

endmodule
`default_nettype wire

// ==== hdl/ess_grabber.sv ====
// Frame grabber end: APB registers, sync generation and frame counting.
`timescale 1ns/1ns
`default_nettype none
module ess_grabber (
  // Clock and reset.
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Link to the camera.
  ess_link_if.grabber      LINK
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  mode;
    logic [31:0] t1;
    logic [31:0] t2;
    logic        sync;
    logic        cfg_stb;
    logic [1:0]  fv_meta;
    logic        fv_s;
    logic        fv_old;
    logic [1:0]  ex_meta;
    logic        ex_s;
    logic [31:0] frames;
    logic [31:0] rdata;
    logic        slverr;
  } ess_grb_t;

  ess_grb_t g_q;
  ess_grb_t g_d;
  logic     acc;
  logic     wr_acc;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    g_d = g_q;
    acc = PSEL & ~PENABLE;
    wr_acc = PSEL & PENABLE & PWRITE;
    g_d.cfg_stb = 1'b0;
    g_d.slverr = 1'b0;
    g_d.fv_meta = {g_q.fv_meta[0], LINK.frame_valid};
    g_d.fv_s    = g_q.fv_meta[1];
    g_d.fv_old  = g_q.fv_s;
    g_d.ex_meta = {g_q.ex_meta[0], LINK.exposing};
    g_d.ex_s    = g_q.ex_meta[1];
    // Frames counted at the fall of frame valid; saturation is not needed at 32 bits.
    if (!g_q.fv_s && g_q.fv_old) begin
      g_d.frames = g_q.frames + 32'h0000_0001;
    end
    // Decode in the setup cycle so the answer is ready in the first access cycle.
    if (acc) begin
      g_d.slverr = 1'b0;
      g_d.rdata  = 32'h0000_0000;
      case (PADDR)
        ess_pkg::REG_MODE:   g_d.rdata = {30'h0, g_q.mode};
        ess_pkg::REG_TIMER1: g_d.rdata = g_q.t1;
        ess_pkg::REG_TIMER2: g_d.rdata = g_q.t2;
        ess_pkg::REG_CTRL:   g_d.rdata = {31'h0, g_q.sync};
        ess_pkg::REG_STATUS: g_d.rdata = {30'h0, g_q.ex_s, g_q.fv_s};
        ess_pkg::REG_FRAMES: g_d.rdata = g_q.frames;
        default:             g_d.slverr = 1'b1;
      endcase
    end
    // Writes land at the access edge, where the master sees pready high.
    if (wr_acc) begin
      begin
        case (PADDR)
          ess_pkg::REG_MODE: begin
            g_d.mode    = PWDATA[1:0];
            g_d.cfg_stb = 1'b1;
          end
          ess_pkg::REG_TIMER1: begin
            g_d.t1      = PWDATA;
            g_d.cfg_stb = 1'b1;
          end
          ess_pkg::REG_TIMER2: begin
            g_d.t2      = PWDATA;
            g_d.cfg_stb = 1'b1;
          end
          // Software paces the sync; timing limits are its duty.
          ess_pkg::REG_CTRL: g_d.sync = PWDATA[0];
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      g_q <= '0;
      g_q.mode <= ess_pkg::MODE_RST;
      g_q.t1   <= ess_pkg::TIMER1_RST;
      g_q.t2   <= ess_pkg::TIMER2_RST;
      g_q.sync <= 1'b1;
    end else begin
      g_q <= g_d;
    end
  end

  assign PRDATA       = g_q.rdata;
  assign PSLVERR      = g_q.slverr;
  assign PREADY       = 1'b1;
  assign LINK.sync    = g_q.sync;
  assign LINK.mode    = g_q.mode;
  assign LINK.timer1  = g_q.t1;
  assign LINK.timer2  = g_q.t2;
  assign LINK.cfg_stb = g_q.cfg_stb;

endmodule
`default_nettype wire

// ==== hdl/ess_link_if.sv ====
// Link between the camera end and the frame grabber end.
`timescale 1ns/1ns
`default_nettype none
interface ess_link_if;
  logic              sync;
  logic [1:0]        mode;
  logic [31:0]       timer1;
  logic [31:0]       timer2;
  logic              cfg_stb;
  logic              exposing;
  logic              frame_valid;
  logic              line_valid;
  logic [9:0]        pixel;

  modport camera  (input sync, mode, timer1, timer2, cfg_stb,
                   output exposing, frame_valid, line_valid, pixel);
  modport grabber (output sync, mode, timer1, timer2, cfg_stb,
                   input exposing, frame_valid, line_valid, pixel);
endinterface
`default_nettype wire

// ==== hdl/ess_pkg.sv ====
// Shared constants, timing figures and types of the exposure sync sequencer.
package ess_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int DATA_DIV         = 6;      // 250 / 6 approximates the 40 MHz data rate.
  localparam int START_LAG_NS     = 3700;
  localparam int START_LAG_CYC    = (START_LAG_NS * CLK_MHZ + 999) / 1000;
  localparam int JITTER_MAX_NS    = 25000;
  localparam int JITTER_MAX_CYC   = (JITTER_MAX_NS * CLK_MHZ) / 1000;
  localparam int EXTRA_EXP_NS     = 94500;
  localparam int EXTRA_EXP_CYC    = (EXTRA_EXP_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_HIGH_MIN_NS = 4000;
  localparam int SYNC_HIGH_MIN_CYC = (SYNC_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_LOW_MIN_NS  = 10000;
  localparam int SYNC_LOW_MIN_CYC = (SYNC_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int FV_GUARD_NS      = 1000;
  localparam int FV_GUARD_CYC     = (FV_GUARD_NS * CLK_MHZ + 999) / 1000;
  localparam int LINE_GAP_NS      = 7900;
  localparam int LINE_GAP_CYC     = (LINE_GAP_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------------------
  // Geometry and data
  // ---------------------------------------------------------------------------
  localparam int PIX_W        = 10;
  localparam int LINE_PIX     = 1004;
  localparam int HALF_PIX     = 502;
  localparam int FRAME_LINES  = 1004;
  localparam int CNT_W        = 32;

  // ---------------------------------------------------------------------------
  // Modes and reset values
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ESS_MODE_LEVEL = 2'h0,
    ESS_MODE_PROG  = 2'h1,
    ESS_MODE_FREE  = 2'h2
  } ess_mode_t;

  localparam logic [CNT_W-1:0] TIMER1_RST = 32'h0000_05DC;
  localparam logic [CNT_W-1:0] TIMER2_RST = 32'h0000_2710;
  localparam logic [1:0]       MODE_RST   = 2'h0;

  // ---------------------------------------------------------------------------
  // Register map of the controller's own APB slave
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_MODE   = 8'h00;
  localparam logic [7:0] REG_TIMER1 = 8'h04;
  localparam logic [7:0] REG_TIMER2 = 8'h08;
  localparam logic [7:0] REG_CTRL   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FRAMES = 8'h14;

endpackage

// ==== verification/ess_link_asserts.sv ====
// Concurrent checks on the link between the camera end and the grabber end.
`timescale 1ns/1ns
`default_nettype none
module ess_link_asserts (
  // Clock and reset.
  input wire logic        CLOCK,
  input wire logic        RSTN,
  // Link signals.
  input wire logic        sync,
  input wire logic [1:0]  mode,
  input wire logic [31:0] timer1,
  input wire logic        exposing,
  input wire logic        frame_valid,
  input wire logic        line_valid,
  input wire logic [9:0]  pixel
);
  // -------------------------------------------------------------------------
  // Cycle counters
  // -------------------------------------------------------------------------
  localparam int LAG = ess_pkg::START_LAG_CYC;
  localparam int EXT = ess_pkg::EXTRA_EXP_CYC;
  localparam int LPX = ess_pkg::LINE_PIX * ess_pkg::DATA_DIV;

  typedef struct packed {
    logic        ps;
    logic [15:0] sf;
    logic [15:0] sr;
    logic [31:0] ec;
    logic [15:0] lc;
  } ess_chk_t;

  ess_chk_t s_q;
  ess_chk_t s_d;

  // The sync edge counts saturate so that a long idle spell cannot wrap into a legal window.
  always_comb begin
    s_d    = s_q;
    s_d.ps = sync;
    s_d.sf = (s_q.ps && !sync) ? 16'h0 : s_q.sf + {15'h0, ~&s_q.sf};
    s_d.sr = (!s_q.ps && sync) ? 16'h0 : s_q.sr + {15'h0, ~&s_q.sr};
    s_d.ec = exposing ? s_q.ec + 32'h1 : 32'h0;
    s_d.lc = line_valid ? s_q.lc + 16'h1 : 16'h0;
  end

  // Registers the counters.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking dcb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  a_prog_start_lag : assert property (
    mode == 2'h1 && $rose(exposing) |-> s_q.sr >= LAG - 2 && s_q.sr <= LAG + 8)
    else $error("programmable exposure start is off its lag");
  a_level_start_lag : assert property (
    mode == 2'h0 && $rose(exposing) |->
      s_q.sf >= LAG - 2 && s_q.sf <= (frame_valid ? ess_pkg::JITTER_MAX_CYC : LAG) + 8)
    else $error("level exposure start is off its lag");
  a_level_exp_end : assert property (
    mode == 2'h0 && $fell(exposing) |-> s_q.sr >= EXT - 2 && s_q.sr <= EXT + 8)
    else $error("level exposure end is off the sync rise");
  a_timed_exp_len : assert property (
    mode != 2'h0 && $fell(exposing) |-> s_q.ec >= timer1 + EXT - 1 && s_q.ec <= timer1 + EXT + 2)
    else $error("timed exposure has the wrong length");
  a_readout_follows : assert property (
    $fell(exposing) |-> ##[1:1000] frame_valid)
    else $error("no frame after the exposure ended");
  a_pixel_pace : assert property (
    line_valid && $past(line_valid) && $changed(pixel) |-> ##6 ($changed(pixel) || !line_valid))
    else $error("pixel not held for one data tick");
  a_line_length : assert property (
    $fell(line_valid) |-> s_q.lc >= LPX - 4 && s_q.lc <= LPX + 4)
    else $error("line has the wrong length");
  a_line_in_frame : assert property (
    line_valid |-> frame_valid)
    else $error("line valid outside frame valid");

  // Main scenarios reached.
  c_level_exp : cover property (mode == 2'h0 && $rose(exposing));
  c_prog_exp : cover property (mode == 2'h1 && $rose(exposing));
  c_free_exp : cover property (mode == 2'h2 && $rose(exposing));
  c_line_done : cover property ($fell(line_valid));
endmodule
`default_nettype wire

// ==== verification/exposure_sync_sequencer_tb_top.sv ====
// Testbench joining camera and grabber ends, driven over APB.
`timescale 1ns/1ns
`default_nettype none
module exposure_sync_sequencer_tb_top;
  localparam int LAG = ess_pkg::START_LAG_CYC;
  localparam int EXT = ess_pkg::EXTRA_EXP_CYC;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  sample;
  logic [10:0] saddr;
  logic [9:0]  mask;
  logic [9:0]  lpix;
  logic [9:0]  first;
  logic [31:0] rd;
  logic        er;
  logic        ps;
  logic        pe;
  logic        pl;
  int          seed;
  int          cyc;
  int          t_sf;
  int          t_sr;
  int          t_er;
  int          t_ef;
  int          npix;
  int          nlines;
  int          t1;
  int          t2;
  int          low;
  int          n_mismatch;
  int          num_checks;

  ess_link_if link ();

  ess_camera i_ess_camera (.CLOCK(clk), .RSTN(rst_n), .LINK(link), .SENSOR_SAMPLE(sample), .SENSOR_ADDR(saddr));
  ess_grabber i_ess_grabber (.CLOCK(clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  ess_link_asserts i_ess_link_asserts (.CLOCK(clk), .RSTN(rst_n), .sync(link.sync), .mode(link.mode),
    .timer1(link.timer1), .exposing(link.exposing), .frame_valid(link.frame_valid),
    .line_valid(link.line_valid), .pixel(link.pixel));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  // Turns a shift register position back into the pixel index stored there.
  // Left positions hold pixels in order; right positions start from the last pixel.
  function automatic logic [9:0] pix_of(input logic [10:0] a);
    if (a < 11'(ess_pkg::HALF_PIX)) return a[9:0];
    return 10'(11'(ess_pkg::LINE_PIX - 1 + ess_pkg::HALF_PIX) - a);
  endfunction

  // Sensor answers with its pixel index scrambled by a random mask, so order stays decodable.
  always @(posedge clk) sample <= pix_of(saddr) ^ mask;

  // -------------------------------------------------------------------------
  // Link monitor
  // -------------------------------------------------------------------------
  // Records edge times and checks pixel order; reset cuts lines short, so it is skipped then.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ps  <= link.sync;
    pe  <= link.exposing;
    pl  <= link.line_valid && rst_n;
    if (ps && !link.sync) t_sf <= cyc;
    if (!ps && link.sync) t_sr <= cyc;
    if (!pe && link.exposing) t_er <= cyc;
    if (pe && !link.exposing) t_ef <= cyc;
    if (rst_n && link.line_valid && (!pl || link.pixel !== lpix)) begin
      lpix <= link.pixel;
      npix <= pl ? npix + 1 : 1;
      if (pl) chk("pixel order", 32'((lpix ^ mask) + 10'h1), 32'(link.pixel ^ mask));
      else if (nlines == 0) first <= link.pixel;
      else chk("line start", 32'(first), 32'(link.pixel));
    end
    if (rst_n && pl && !link.line_valid) begin
      chk("line pixels", 32'(ess_pkg::LINE_PIX), 32'(npix));
      nlines <= nlines + 1;
    end
  end

  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    chk("pready", 32'h1, 32'(pready));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic cond(input int s);
    case (s)
      0: return link.exposing;
      1: return link.frame_valid;
      default: return link.line_valid && nlines > 0;
    endcase
  endfunction

  // Bounded wait; one extra edge lets the monitor's times land.
  task automatic wait_on(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (cond(s) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk_rng("wait cycles", 0, lim - 1, n);
    @(posedge clk);
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata, pe, pl} = '0;
    {cyc, npix, nlines, n_mismatch, num_checks} = '0;
    ps   = 1'b1;
    seed = 90800;
    mask = 10'($random(seed));
    sample = 10'h0;
    t1  = 1500 + ($random(seed) & 255);
    t2  = 1000 + ($random(seed) & 255);
    low = 2500 + ($random(seed) & 511);
    do_reset;
    apb(1'b0, ess_pkg::REG_MODE, 32'h0);
    chk("mode reset", {30'h0, ess_pkg::MODE_RST}, rd);
    apb(1'b0, ess_pkg::REG_TIMER2, 32'h0);
    chk("timer2 reset", ess_pkg::TIMER2_RST, rd);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk("unmapped error", 32'h1, 32'(er));
    apb(1'b1, ess_pkg::REG_TIMER1, 32'(t1));
    apb(1'b0, ess_pkg::REG_TIMER1, 32'h0);
    chk("timer1", 32'(t1), rd);
    apb(1'b1, ess_pkg::REG_MODE, 32'h1);
    // Programmable: the fall must do nothing, the rise starts a timed exposure.
    apb(1'b1, ess_pkg::REG_CTRL, 32'h0);
    repeat (1500) @(posedge clk);
    chk("exposing after fall", 32'h0, 32'(link.exposing));
    apb(1'b1, ess_pkg::REG_CTRL, 32'h1);
    wait_on(0, 1'b1, 2000);
    chk_rng("prog start lag", LAG - 2, LAG + 8, t_er - t_sr);
    apb(1'b1, ess_pkg::REG_CTRL, 32'h0);
    repeat (1100) @(posedge clk);
    apb(1'b1, ess_pkg::REG_CTRL, 32'h1);
    wait_on(0, 1'b0, 40000);
    chk_rng("prog width", t1 + EXT - 1, t1 + EXT + 2, t_ef - t_er);
    wait_on(1, 1'b1, 2000);
    apb(1'b0, ess_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h1, {30'h0, rd[1:0]});
    // Level: exposure spans the low time, the frame follows the rise.
    do_reset;
    chk("fv before fall", 32'h0, 32'(link.frame_valid));
    apb(1'b1, ess_pkg::REG_CTRL, 32'h0);
    repeat (low) @(posedge clk);
    chk("fv before rise", 32'h0, 32'(link.frame_valid));
    apb(1'b1, ess_pkg::REG_CTRL, 32'h1);
    wait_on(0, 1'b0, 30000);
    chk_rng("level start lag", LAG - 2, LAG + 8, t_er - t_sf);
    chk_rng("level end", EXT - 2, EXT + 8, t_ef - t_sr);
    wait_on(2, 1'b1, 20000);
    // Free-run: no sync activity, timers alone pace the exposures.
    do_reset;
    apb(1'b1, ess_pkg::REG_TIMER1, 32'(t1));
    apb(1'b1, ess_pkg::REG_TIMER2, 32'(t2));
    apb(1'b1, ess_pkg::REG_MODE, 32'h2);
    wait_on(0, 1'b1, 40000);
    wait_on(0, 1'b0, 40000);
    chk_rng("free width", t1 + EXT - 1, t1 + EXT + 2, t_ef - t_er);
    wait_on(0, 1'b1, 40000);
    chk_rng("free gap", t2 - 2, t2 + 8, t_er - t_ef);
    end_sim;
  end

  // Watchdog sized above the longest legal run of the sequence.
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
